// ### src/astc_pkg.sv
// Operation
// - shared sample time is field value plus two conversion clock periods.
// - a shared trigger starts sampling first, then conversion follows.
// - each scanned input takes sample count plus resolution bits plus three periods.
// - ref ready enable set raises interrupt when ref ready flag sets.
// - ref fault enable set raises interrupt when ref fault flag sets.
// - scan end enable set raises interrupt when scan end flag sets.
// - override bit selects global or early enable registers for data interrupts.
// - early data interrupt comes select clocks before conversion end.
// - per dedicated converter, bits 8-13 choose presynchronized triggers.
// - per dedicated converter, bits 0-5 sync the first sample after idle.
// - dedicated converter control and results stay on the native input slot.
package astc_pkg;
  localparam logic [3:0] ADDR_CONTROL_TWO = 4'h0;
  localparam logic [3:0] ADDR_TRIGGER_MODE = 4'h1;
  localparam logic [3:0] ADDR_CONTROL_ONE = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;
  localparam logic [3:0] ADDR_MASK = 4'h4;
  localparam logic [3:0] ADDR_GLOBAL_EN = 4'h5;
  localparam logic [3:0] ADDR_EARLY_EN = 4'h6;
  localparam logic [3:0] ADDR_SCAN_LIST = 4'h7;
  localparam logic [31:0] CONTROL_TWO_MASK = 32'h03FF_F700;
  localparam logic [31:0] TRIGGER_MODE_MASK = 32'h0000_3F3F;
  localparam logic [31:0] CONTROL_TWO_RESET = 32'h0000_0000;
  localparam logic [31:0] TRIGGER_MODE_RESET = 32'h0000_0000;
  localparam int SAMPLE_LSB = 16;
  localparam int REF_READY_IEN_BIT = 15;
  localparam int REF_FAULT_IEN_BIT = 14;
  localparam int SCAN_END_IEN_BIT = 13;
  localparam int OVERRIDE_BIT = 12;
  localparam int LEAD_LSB = 8;
  localparam int PRESYNC_LSB = 8;
  localparam int SYNC_LSB = 0;
  localparam int RES_LSB = 0;
  localparam int NUM_DED = 6;
  localparam int NUM_IN = 8;
  localparam logic [10:0] SAMPLE_EXTRA = 11'h002;
  localparam logic [10:0] CONVERT_EXTRA = 11'h001;
  localparam int STAT_REF_READY = 0;
  localparam int STAT_REF_FAULT = 1;
  localparam int STAT_SCAN_END = 2;
  localparam int STAT_DATA = 3;
  localparam logic [6:0] DIVIDER_RESET = 7'h01;
  typedef enum logic [1:0] {
    RES_6_BIT, RES_8_BIT, RES_10_BIT, RES_12_BIT
  } astc_res_type;
endpackage

// ### src/astc_tick.sv
`timescale 1ns/1ns
// conversion clock enable: one pulse every divider+1 system clocks
module astc_tick (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [6:0] divider,
  output logic tick
);
  import astc_pkg::*;
  logic [6:0] count;
  wire count_done = (count >= divider);
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      count <= 7'h00;
      tick <= 1'b0;
    end else begin
      count <= count_done ? 7'h00 : count + 7'h01;
      tick <= count_done;
    end
  end
endmodule

// ### src/astc_dedicated.sv
`timescale 1ns/1ns
// one dedicated converter: trigger conditioning and first-sample marking
module astc_dedicated (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic presync_sel,
  input wire logic sync_sel,
  input wire logic trig_raw,
  input wire logic trig_presync,
  input wire logic busy,
  output logic start,
  output logic start_sync
);
  import astc_pkg::*;
  logic meta;
  logic synced;
  logic synced_d;
  logic idle_seen;
  wire async_edge = synced & ~synced_d;
  // presynchronized source needs no extra stages
  wire fire = enable & (presync_sel ? trig_presync : async_edge);
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      meta <= 1'b0;
      synced <= 1'b0;
      synced_d <= 1'b0;
      idle_seen <= 1'b1;
      start <= 1'b0;
      start_sync <= 1'b0;
    end else begin
      meta <= trig_raw;
      synced <= meta;
      synced_d <= synced;
      start <= fire;
      start_sync <= fire & sync_sel & idle_seen;
      if (!enable || (!busy && !fire)) begin
        idle_seen <= 1'b1;
      end else if (fire) begin
        idle_seen <= 1'b0;
      end
    end
  end
endmodule

// ### src/astc_top.sv
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ns
module astc_top (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire logic shared_trigger,
  input wire logic ref_ready_flag,
  input wire logic ref_fault_flag,
  input wire logic [astc_pkg::NUM_DED-1:0] ded_trig_raw,
  input wire logic [astc_pkg::NUM_DED-1:0] ded_trig_presync,
  input wire logic [astc_pkg::NUM_DED-1:0] ded_busy,
  output logic [astc_pkg::NUM_DED-1:0] ded_start,
  output logic [astc_pkg::NUM_DED-1:0] ded_start_sync,
  output logic shared_sampling,
  output logic shared_converting,
  output logic [2:0] shared_input,
  output logic data_irq,
  output logic irq
);
  import astc_pkg::*;

  // ----------------------------------------------------------
  // registers
  // ----------------------------------------------------------
  logic [31:0] adc_control_two;
  logic [31:0] dedicated_converter_trigger_mode;
  logic [8:0] control_one;
  logic [3:0] status;
  logic [3:0] mask;
  logic [NUM_IN-1:0] global_irq_enable;
  logic [NUM_IN-1:0] early_irq_enable;
  logic [NUM_IN-1:0] scan_list_select;

  wire wr_ctl2 = reg_write && reg_addr == ADDR_CONTROL_TWO;
  wire wr_trg = reg_write && reg_addr == ADDR_TRIGGER_MODE;
  wire wr_ctl1 = reg_write && reg_addr == ADDR_CONTROL_ONE;
  wire wr_mask = reg_write && reg_addr == ADDR_MASK;
  wire wr_gen = reg_write && reg_addr == ADDR_GLOBAL_EN;
  wire wr_een = reg_write && reg_addr == ADDR_EARLY_EN;
  wire wr_scan = reg_write && reg_addr == ADDR_SCAN_LIST;
  wire rd_status = reg_read && reg_addr == ADDR_STATUS;

  wire [9:0] shared_sample_count = adc_control_two[SAMPLE_LSB +: 10];
  wire ref_ready_irq_enable = adc_control_two[REF_READY_IEN_BIT];
  wire ref_fault_irq_enable = adc_control_two[REF_FAULT_IEN_BIT];
  wire scan_end_irq_enable = adc_control_two[SCAN_END_IEN_BIT];
  wire early_irq_override = adc_control_two[OVERRIDE_BIT];
  wire [2:0] early_irq_lead_select = adc_control_two[LEAD_LSB +: 3];
  wire [1:0] resolution_select = control_one[RES_LSB +: 2];
  wire [6:0] conversion_clock_divider = control_one[8:2];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      adc_control_two <= CONTROL_TWO_RESET;
    end else if (wr_ctl2) begin
      adc_control_two <= reg_wdata & CONTROL_TWO_MASK;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dedicated_converter_trigger_mode <= TRIGGER_MODE_RESET;
    end else if (wr_trg) begin
      dedicated_converter_trigger_mode <=
        reg_wdata & TRIGGER_MODE_MASK;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      control_one <= {DIVIDER_RESET, 2'b11};
    end else if (wr_ctl1) begin
      control_one <= reg_wdata[8:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mask <= 4'h0;
    end else if (wr_mask) begin
      mask <= reg_wdata[3:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      global_irq_enable <= 8'h00;
    end else if (wr_gen) begin
      global_irq_enable <= reg_wdata[NUM_IN-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      early_irq_enable <= 8'h00;
    end else if (wr_een) begin
      early_irq_enable <= reg_wdata[NUM_IN-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      scan_list_select <= 8'h01;
    end else if (wr_scan) begin
      scan_list_select <= reg_wdata[NUM_IN-1:0];
    end
  end

  // ----------------------------------------------------------
  // conversion clock enable
  // ----------------------------------------------------------
  logic tad_tick;
  astc_tick u_tick (
    .mclk(mclk),
    .rst_n(rst_n),
    .divider(conversion_clock_divider),
    .tick(tad_tick)
  );

  // ----------------------------------------------------------
  // shared converter sequencer
  // ----------------------------------------------------------
  typedef enum logic [1:0] {
    SH_IDLE, SH_SAMPLE, SH_CONVERT
  } astc_shared_type;
  astc_shared_type state;
  astc_shared_type next_state;
  logic [10:0] tad_count;
  logic [2:0] input_idx;
  logic trig_meta;
  logic trig_sync;
  logic trig_sync_d;
  logic scan_end_event;
  logic data_event;

  wire trig_edge = trig_sync & ~trig_sync_d;
  wire [10:0] sample_len = {1'b0, shared_sample_count} + SAMPLE_EXTRA;
  // conversion bits for each resolution code
  wire [10:0] res_bits =
    (resolution_select == RES_6_BIT) ? 11'h006 :
    (resolution_select == RES_8_BIT) ? 11'h008 :
    (resolution_select == RES_10_BIT) ? 11'h00A : 11'h00C;
  wire [10:0] convert_len = res_bits + CONVERT_EXTRA;
  wire [10:0] lead = {8'h00, early_irq_lead_select} + 11'h001;
  wire sample_done = tad_tick && tad_count == sample_len - 11'h001;
  wire convert_done = tad_tick && tad_count == convert_len - 11'h001;
  // early point: lead minus one clocks before conversion ends
  wire early_point = tad_tick && state == SH_CONVERT &&
    tad_count + lead == convert_len;
  wire [NUM_IN-1:0] cur_onehot = 8'h01 << input_idx;
  wire [NUM_IN-1:0] later_mask = ~((cur_onehot << 1) - 8'h01);
  wire [NUM_IN-1:0] later = scan_list_select & later_mask;
  wire more_inputs = |later;
  logic [2:0] next_idx;
  logic [2:0] first_idx;
  always_comb begin
    next_idx = input_idx;
    first_idx = 3'h0;
    for (int i = NUM_IN - 1; i >= 0; i--) begin
      if (later[i]) begin
        next_idx = 3'(i);
      end
      if (scan_list_select[i]) begin
        first_idx = 3'(i);
      end
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      SH_IDLE: begin
        if (trig_edge) begin
          next_state = SH_SAMPLE;
        end
      end
      SH_SAMPLE: begin
        if (sample_done) begin
          next_state = SH_CONVERT;
        end
      end
      SH_CONVERT: begin
        if (convert_done) begin
          next_state = more_inputs ? SH_SAMPLE : SH_IDLE;
        end
      end
      default: begin
        next_state = SH_IDLE;
      end
    endcase
  end

  // data interrupt source: override picks global enables
  wire [NUM_IN-1:0] data_enables =
    early_irq_override ? global_irq_enable : early_irq_enable;
  wire data_fire = early_irq_override ? convert_done : early_point;
  wire data_hit = data_fire && state == SH_CONVERT &&
    data_enables[input_idx];

  // pin level passes two stages before the edge detector reads it
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      trig_meta <= 1'b0;
      trig_sync <= 1'b0;
      trig_sync_d <= 1'b0;
    end else begin
      trig_meta <= shared_trigger;
      trig_sync <= trig_meta;
      trig_sync_d <= trig_sync;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state <= SH_IDLE;
      tad_count <= 11'h000;
      input_idx <= 3'h0;
      scan_end_event <= 1'b0;
      data_event <= 1'b0;
    end else begin
      state <= next_state;
      scan_end_event <= state == SH_CONVERT && convert_done && !more_inputs;
      data_event <= data_hit;
      // each phase counts its ticks from zero
      if (state != next_state) begin
        tad_count <= 11'h000;
      end else if (tad_tick) begin
        tad_count <= tad_count + 11'h001;
      end
      if (state == SH_IDLE && trig_edge) begin
        input_idx <= first_idx;
      end else if (state == SH_CONVERT && convert_done && more_inputs) begin
        input_idx <= next_idx;
      end
    end
  end

  // ----------------------------------------------------------
  // status and interrupt
  // ----------------------------------------------------------
  logic ready_d;
  logic fault_m;
  logic fault_s;
  logic fault_d;
  logic ready_m;
  logic ready_s;
  wire [3:0] events = {
    data_event,
    scan_end_event & scan_end_irq_enable,
    fault_s & ~fault_d & ref_fault_irq_enable,
    ready_s & ~ready_d & ref_ready_irq_enable
  };
  // a new event wins over the clearing read
  wire [3:0] next_status = (rd_status ? 4'h0 : status) | events;

  // reference flags pass two stages before the edge detectors
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ready_m <= 1'b0;
      ready_s <= 1'b0;
      ready_d <= 1'b0;
      fault_m <= 1'b0;
      fault_s <= 1'b0;
      fault_d <= 1'b0;
    end else begin
      ready_m <= ref_ready_flag;
      ready_s <= ready_m;
      ready_d <= ready_s;
      fault_m <= ref_fault_flag;
      fault_s <= fault_m;
      fault_d <= fault_s;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      status <= 4'h0;
      irq <= 1'b0;
      data_irq <= 1'b0;
    end else begin
      status <= next_status;
      irq <= |(next_status & mask);
      data_irq <= data_hit;
    end
  end

  // ----------------------------------------------------------
  // dedicated converters
  // ----------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_DED; g++) begin : gen_ded
      // control always belongs to the native slot of converter g
      astc_dedicated u_ded (
        .mclk(mclk),
        .rst_n(rst_n),
        .enable(1'b1),
        .presync_sel(dedicated_converter_trigger_mode[PRESYNC_LSB + g]),
        .sync_sel(dedicated_converter_trigger_mode[SYNC_LSB + g]),
        .trig_raw(ded_trig_raw[g]),
        .trig_presync(ded_trig_presync[g]),
        .busy(ded_busy[g]),
        .start(ded_start[g]),
        .start_sync(ded_start_sync[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------
  // outputs and read back
  // ----------------------------------------------------------
  logic [31:0] rd_value;
  always_comb begin
    case (reg_addr)
      ADDR_CONTROL_TWO: rd_value = adc_control_two;
      ADDR_TRIGGER_MODE: rd_value = dedicated_converter_trigger_mode;
      ADDR_CONTROL_ONE: rd_value = {23'h0, control_one};
      ADDR_STATUS: rd_value = {28'h0, status};
      ADDR_MASK: rd_value = {28'h0, mask};
      ADDR_GLOBAL_EN: rd_value = {24'h0, global_irq_enable};
      ADDR_EARLY_EN: rd_value = {24'h0, early_irq_enable};
      ADDR_SCAN_LIST: rd_value = {24'h0, scan_list_select};
      default: rd_value = 32'h0;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0;
      shared_sampling <= 1'b0;
      shared_converting <= 1'b0;
      shared_input <= 3'h0;
    end else begin
      reg_rdata <= reg_read ? rd_value : 32'h0;
      shared_sampling <= next_state == SH_SAMPLE;
      shared_converting <= next_state == SH_CONVERT;
      shared_input <= input_idx;
    end
  end
endmodule

// ### bench/astc_top_props.sv
`timescale 1ns/1ns
module astc_top_props
  import astc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic [astc_pkg::NUM_DED-1:0] ded_start,
  input wire logic [astc_pkg::NUM_DED-1:0] ded_start_sync,
  input wire logic shared_sampling,
  input wire logic shared_converting,
  input wire logic data_irq
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  a_ctl_two_unused: assert property ($past(reg_read) &&
    $past(reg_addr) == ADDR_CONTROL_TWO |-> !(reg_rdata & ~CONTROL_TWO_MASK))
    else $error("control two unused bits set");
  a_trg_mode_unused: assert property ($past(reg_read) &&
    $past(reg_addr) == ADDR_TRIGGER_MODE |-> !(reg_rdata & ~TRIGGER_MODE_MASK))
    else $error("trigger mode unused bits set");
  a_unmapped_zero: assert property ($past(reg_read) &&
    $past(reg_addr) > ADDR_SCAN_LIST |-> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_sync_with_start: assert property (
    (ded_start_sync & ~ded_start) == 6'h0)
    else $error("sync mark without start");
  a_data_irq_pulse: assert property (data_irq |=> !data_irq)
    else $error("data interrupt longer than one cycle");
  a_sample_conv_excl: assert property (
    !(shared_sampling && shared_converting))
    else $error("sampling and converting together");
  a_conv_follows: assert property (
    $fell(shared_sampling) |-> shared_converting)
    else $error("conversion did not follow sampling");
  a_conv_cause: assert property (
    $rose(shared_converting) |-> $past(shared_sampling))
    else $error("conversion without sampling");
  a_sample_min: assert property (
    $rose(shared_sampling) |-> shared_sampling[*2])
    else $error("sampling shorter than two periods");
endmodule
bind astc_top astc_top_props u_astc_top_props (.mclk(mclk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .ded_start(ded_start), .ded_start_sync(ded_start_sync),
  .shared_sampling(shared_sampling), .shared_converting(shared_converting),
  .data_irq(data_irq));

// ### bench/astc_top_tb.sv
`timescale 1ns/1ns
module astc_top_tb;
  import astc_pkg::*;
  logic mclk, rst_n, reg_write, reg_read, shared_trigger, data_irq, irq;
  logic ref_ready_flag, ref_fault_flag, shared_sampling, shared_converting;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [2:0] shared_input;
  logic [NUM_DED-1:0] ded_trig_raw, ded_trig_presync, ded_busy;
  logic [NUM_DED-1:0] ded_start, ded_start_sync;
  logic [31:0] rst_tab [0:8] = '{32'h0, 32'h0, 32'h7, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h1, 32'h0};
  int mismatches = 0;
  int checked = 0;
  astc_top u_astc_top (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .shared_trigger(shared_trigger),
    .ref_ready_flag(ref_ready_flag), .ref_fault_flag(ref_fault_flag),
    .ded_trig_raw(ded_trig_raw), .ded_trig_presync(ded_trig_presync),
    .ded_busy(ded_busy), .ded_start(ded_start),
    .ded_start_sync(ded_start_sync), .shared_sampling(shared_sampling),
    .shared_converting(shared_converting), .shared_input(shared_input),
    .data_irq(data_irq), .irq(irq));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // ----------------------------------------
  // bus and compare helpers
  // ----------------------------------------
  task check(input string name, input logic [31:0] seen, input logic [31:0] e);
    checked++;
    if (seen !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, e, seen);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task test_regs;
    for (int i = 0; i < 9; i++) begin
      rd(i[3:0], d);
      check("reset value", d, rst_tab[i]);
    end
    wr(ADDR_CONTROL_TWO, 32'hFFFF_FFFF);
    wr(ADDR_TRIGGER_MODE, 32'hFFFF_FFFF);
    wr(4'h9, 32'hFFFF_FFFF);
    rd(ADDR_CONTROL_TWO, d);
    check("control two", d, CONTROL_TWO_MASK);
    rd(ADDR_TRIGGER_MODE, d);
    check("trigger mode", d, TRIGGER_MODE_MASK);
    rd(4'h9, d);
    check("unmapped", d, 32'h0);
    wr(ADDR_CONTROL_TWO, 32'h0);
    wr(ADDR_TRIGGER_MODE, 32'h0);
    $display("test registers done");
  endtask
  task ref_event(input logic [31:0] c2, input logic [3:0] msk,
    input logic fault, input logic [31:0] est, input logic eirq);
    wr(ADDR_CONTROL_TWO, c2);
    wr(ADDR_MASK, {28'h0, msk});
    @(posedge mclk);
    ref_fault_flag <= fault;
    ref_ready_flag <= !fault;
    repeat (3) @(posedge mclk);
    ref_fault_flag <= 1'b0;
    ref_ready_flag <= 1'b0;
    repeat (4) @(posedge mclk);
    #1 check("irq", {31'h0, irq}, {31'h0, eirq});
    rd(ADDR_STATUS, d);
    check("status", d, est);
    repeat (2) @(posedge mclk);
    #1 check("irq cleared", {31'h0, irq}, 32'h0);
  endtask
  task shared_run(input logic [31:0] c1, c2, ge, ee, input int ns, nc, nd,
    input logic [31:0] est, input logic [2:0] li);
    int s, c, q, a;
    s = 0;
    c = 0;
    q = 0;
    a = 0;
    wr(ADDR_CONTROL_ONE, c1);
    wr(ADDR_CONTROL_TWO, c2);
    wr(ADDR_GLOBAL_EN, ge);
    wr(ADDR_EARLY_EN, ee);
    wr(ADDR_MASK, 32'h4);
    @(posedge mclk);
    shared_trigger <= 1'b1;
    // sampling starts at the third edge, so counting starts there
    repeat (2) @(posedge mclk);
    shared_trigger <= 1'b0;
    repeat (60) begin
      @(posedge mclk);
      #1 if (shared_sampling === 1'b1) s++;
      if (shared_converting === 1'b1) c++;
      if (data_irq === 1'b1) q++;
      if (q > 0 && shared_converting === 1'b1) a++;
    end
    check("sample periods", s, ns);
    check("convert periods", c, nc);
    check("data irq count", q, nd);
    check("early lead", a,
      (c2[12] || nd == 0) ? 32'h0 : {29'h0, c2[10:8]});
    check("scan input", {29'h0, shared_input}, {29'h0, li});
    rd(ADDR_STATUS, d);
    check("scan end status", d & 32'h4, est);
    repeat (2) @(posedge mclk);
    #1 check("irq after scan", {31'h0, irq}, 32'h0);
  endtask
  task ded_fire(input logic [5:0] raw, pre, es, ey);
    logic [5:0] st, sy;
    st = 6'h0;
    sy = 6'h0;
    @(posedge mclk);
    ded_trig_raw <= raw;
    ded_trig_presync <= pre;
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      if (i == 0) ded_trig_presync <= 6'h0;
      if (i == 2) ded_trig_raw <= 6'h0;
      #1 st = st | ded_start;
      sy = sy | ded_start_sync;
    end
    check("ded start", {26'h0, st}, {26'h0, es});
    check("ded sync", {26'h0, sy}, {26'h0, ey});
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    finish_test();
  end
  initial begin
    {rst_n, reg_write, reg_read, shared_trigger} = 4'h0;
    {ref_ready_flag, ref_fault_flag, reg_addr, reg_wdata} = 38'h0;
    {ded_trig_raw, ded_trig_presync, ded_busy} = 18'h0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    test_regs();
    ref_event(32'h8000, 4'h3, 1'b0, 32'h1, 1'b1);
    ref_event(32'h0, 4'h3, 1'b1, 32'h0, 1'b0);
    ref_event(32'h4000, 4'h3, 1'b1, 32'h2, 1'b1);
    ref_event(32'h8000, 4'h0, 1'b0, 32'h1, 1'b0);
    $display("test reference events done");
    shared_run(32'h0, 32'h0003_2200, 32'h0, 32'h1,
      5, 7, 1, 32'h4, 3'h0);
    shared_run(32'h3, 32'h0000_1000, 32'h0, 32'h1,
      2, 13, 0, 32'h0, 3'h0);
    shared_run(32'h3, 32'h0000_1000, 32'h1, 32'h0,
      2, 13, 1, 32'h0, 3'h0);
    wr(ADDR_SCAN_LIST, 32'h5);
    shared_run(32'h0, 32'h0000_2000, 32'h0, 32'h0,
      4, 14, 0, 32'h4, 3'h2);
    $display("test shared converter done");
    wr(ADDR_TRIGGER_MODE, 32'h0000_0101);
    ded_fire(6'h00, 6'h01, 6'h01, 6'h01);
    ded_fire(6'h01, 6'h00, 6'h00, 6'h00);
    ded_fire(6'h02, 6'h00, 6'h02, 6'h00);
    ded_fire(6'h00, 6'h02, 6'h00, 6'h00);
    @(posedge mclk);
    ded_busy <= 6'h01;
    ded_fire(6'h00, 6'h01, 6'h01, 6'h01);
    ded_fire(6'h00, 6'h01, 6'h01, 6'h00);
    $display("test dedicated converters done");
    finish_test();
  end
endmodule
